// File: hw/hkad_interval_timer.sv
`timescale 1ns/1ps
module hkad_interval_timer #(
    parameter int W = hkad_pkg::PERIOD_S_W
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_sec_tick,
    input  wire logic [W-1:0] i_period_s,
    output logic              o_expire
);
    if (W < 1) begin : g_bad_width
        $error("hkad_interval_timer: W must be at least 1");
    end

    typedef struct packed {
        logic [W-1:0] cnt;
        logic [W-1:0] period_last;
        logic         expire;
    } hkad_timer_s;

    hkad_timer_s st_r;
    hkad_timer_s st_nxt;

    always_comb begin
        st_nxt             = st_r;
        st_nxt.expire      = 1'b0;
        st_nxt.period_last = i_period_s;
        // Restart on any change of period, stay cleared to zero while disabled
        if (i_period_s == '0 || i_period_s != st_r.period_last) begin
            st_nxt.cnt = '0;
        end else if (i_sec_tick) begin
            if (st_r.cnt + W'(1) >= i_period_s) begin
                st_nxt.cnt    = '0;
                st_nxt.expire = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_expire = st_r.expire;

endmodule : hkad_interval_timer

// File: hw/hkad_pkg.sv
package hkad_pkg;

    // Special function register addresses
    localparam logic [7:0] ADDR_TEMP_RESULT   = 8'hD7;
    localparam logic [7:0] ADDR_MEASURE_START = 8'hD8;
    localparam logic [7:0] ADDR_BATT_RESULT   = 8'hDF;
    localparam logic [7:0] ADDR_EVENT_ENABLES = 8'hEC;
    localparam logic [7:0] ADDR_EXT_RESULT    = 8'hEF;
    localparam logic [7:0] ADDR_DELTA         = 8'hF3;
    localparam logic [7:0] ADDR_EVENT_FLAGS   = 8'hF8;
    localparam logic [7:0] ADDR_INTERVAL      = 8'hF9;
    localparam logic [7:0] ADDR_LOW_BATT_TH   = 8'hFA;

    // Field positions and widths
    localparam int START_BATT_BIT      = 0;
    localparam int START_TEMP_BIT      = 1;
    localparam int START_W             = 2;
    localparam int IVL_TEMP_LSB        = 0;
    localparam int IVL_BATT_LSB        = 2;
    localparam int IVL_FIELD_W         = 2;
    localparam int IVL_STORE_W         = 4;
    localparam int DELTA_TEMP_LSB      = 3;
    localparam int DELTA_FIELD_W       = 3;
    localparam int DELTA_STORE_W       = 6;
    localparam int FLAG_LOW_BATT_BIT   = 2;
    localparam int ENABLE_LOW_BATT_BIT = 2;

    // Reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // Field encodings
    localparam logic [2:0] DELTA_OFF   = 3'h0;
    localparam logic [2:0] DELTA_EVERY = 3'h7;
    localparam logic [1:0] IVL_OFF     = 2'h0;
    localparam logic [1:0] IVL_CODE_1  = 2'h1;
    localparam logic [1:0] IVL_CODE_2  = 2'h2;

    // Timing
    localparam int PERIOD_S_W      = 10;
    localparam int SEC_PER_MIN     = 60;
    localparam int TEMP_IVL_1_MIN  = 8;
    localparam int TEMP_IVL_2_MIN  = 2;
    localparam int TEMP_IVL_3_MIN  = 1;
    localparam int BATT_IVL_1_MIN  = 16;
    localparam int BATT_IVL_2_MIN  = 4;
    localparam int BATT_IVL_3_MIN  = 1;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int SEC_NS          = 1000000000;
    localparam int SEC_CYCLES_DFLT = SEC_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        HKAD_MODE_MAINS   = 2'h0,
        HKAD_MODE_BATTERY = 2'h1,
        HKAD_MODE_HALTED  = 2'h2
    } hkad_mode_e;

    typedef enum logic [1:0] {
        HKAD_CH_IDLE = 2'b01,
        HKAD_CH_BUSY = 2'b10
    } hkad_chan_e;

endpackage : hkad_pkg

// File: hw/hkad_sec_tick.sv
`timescale 1ns/1ps
module hkad_sec_tick #(
    parameter int unsigned CYCLES = hkad_pkg::SEC_CYCLES_DFLT
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    output logic      o_tick
);
    localparam int CW = $clog2(CYCLES + 1);

    if (CYCLES < 1) begin : g_bad_cycles
        $error("hkad_sec_tick: CYCLES must be at least 1");
    end

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          tick;
    } hkad_tick_s;

    hkad_tick_s st_r;
    hkad_tick_s st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == CW'(CYCLES - 1)) begin
            st_nxt.cnt  = '0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_tick = st_r.tick;

endmodule : hkad_sec_tick

// File: hw/hkad_sequencer.sv
`timescale 1ns/1ps
module hkad_sequencer #(
    parameter int unsigned SEC_CYCLES = hkad_pkg::SEC_CYCLES_DFLT
) (
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_RST_N,
    input  wire logic [7:0] I_SFR_ADDR,
    input  wire logic       I_SFR_WR,
    input  wire logic [7:0] I_SFR_WDATA,
    input  wire logic [1:0] I_POWER_MODE,
    input  wire logic       I_TEMP_CONV_DONE,
    input  wire logic [7:0] I_TEMP_CONV_DATA,
    input  wire logic       I_BATT_CONV_DONE,
    input  wire logic [7:0] I_BATT_CONV_DATA,
    output logic [7:0]      O_SFR_RDATA,
    output logic            O_TEMP_CONV_START,
    output logic            O_BATT_CONV_START,
    output logic            O_TEMP_INTERRUPT,
    output logic            O_POWER_SUPPLY_INTERRUPT
);
    localparam int PW = hkad_pkg::PERIOD_S_W;

    if (SEC_CYCLES < 1) begin : g_bad_sec
        $error("hkad_sequencer: SEC_CYCLES must be at least 1");
    end

    typedef struct packed {
        logic [7:0]                          temp_result;
        logic [7:0]                          batt_result;
        logic [7:0]                          temp_ref;
        logic [7:0]                          low_batt_th;
        logic [hkad_pkg::DELTA_STORE_W-1:0]  delta;
        logic [hkad_pkg::IVL_STORE_W-1:0]    interval;
        logic [hkad_pkg::START_W-1:0]        start_req;
        logic                                low_batt_flag;
        logic                                low_batt_en;
        hkad_pkg::hkad_chan_e                temp_st;
        hkad_pkg::hkad_chan_e                batt_st;
        logic                                temp_single;
        logic                                batt_single;
        logic                                temp_bg_pend;
        logic                                batt_bg_pend;
        logic                                temp_start;
        logic                                batt_start;
        logic                                temp_irq;
        logic                                psi;
        logic [7:0]                          rdata;
    } hkad_seq_s;

    hkad_seq_s st_r;
    hkad_seq_s st_nxt;

    logic          sec_tick;
    logic          temp_expire;
    logic          batt_expire;
    logic [PW-1:0] temp_period_s;
    logic [PW-1:0] battery_interval_field_s;

    // Interval code to period in seconds
    function automatic logic [PW-1:0] period_s(input logic [1:0] code,
                                               input int       min_1,
                                               input int       min_2,
                                               input int       min_3);
        int mins;
        mins = 0;
        if (code == hkad_pkg::IVL_OFF) begin
            mins = 0;
        end else if (code == hkad_pkg::IVL_CODE_1) begin
            mins = min_1;
        end else if (code == hkad_pkg::IVL_CODE_2) begin
            mins = min_2;
        end else begin
            mins = min_3;
        end
        return PW'(mins * hkad_pkg::SEC_PER_MIN);
    endfunction : period_s

    // Delta decision for a background temperature result
    function automatic logic delta_hit(input logic [7:0] new_val,
                                       input logic [7:0] ref_val,
                                       input logic [2:0] code);
        logic [7:0] diff;
        diff = (new_val >= ref_val) ? (new_val - ref_val) : (ref_val - new_val);
        if (code == hkad_pkg::DELTA_OFF) begin
            return 1'b0;
        end else if (code == hkad_pkg::DELTA_EVERY) begin
            return 1'b1;
        end
        return diff > {5'h00, code};
    endfunction : delta_hit

    always_comb begin
        temp_period_s = period_s(
            st_r.interval[hkad_pkg::IVL_TEMP_LSB +: hkad_pkg::IVL_FIELD_W],
            hkad_pkg::TEMP_IVL_1_MIN, hkad_pkg::TEMP_IVL_2_MIN,
            hkad_pkg::TEMP_IVL_3_MIN);
        battery_interval_field_s = period_s(
            st_r.interval[hkad_pkg::IVL_BATT_LSB +: hkad_pkg::IVL_FIELD_W],
            hkad_pkg::BATT_IVL_1_MIN, hkad_pkg::BATT_IVL_2_MIN,
            hkad_pkg::BATT_IVL_3_MIN);
    end

    hkad_sec_tick #(
        .CYCLES (SEC_CYCLES)
    ) u_sec_tick (
        .i_clk   (I_CLK_SYS),
        .i_rst_n (I_RST_N),
        .o_tick  (sec_tick)
    );

    hkad_interval_timer #(
        .W (PW)
    ) u_temp_timer (
        .i_clk      (I_CLK_SYS),
        .i_rst_n    (I_RST_N),
        .i_sec_tick (sec_tick),
        .i_period_s (temp_period_s),
        .o_expire   (temp_expire)
    );

    hkad_interval_timer #(
        .W (PW)
    ) u_batt_timer (
        .i_clk      (I_CLK_SYS),
        .i_rst_n    (I_RST_N),
        .i_sec_tick (sec_tick),
        .i_period_s (battery_interval_field_s),
        .o_expire   (batt_expire)
    );

    always_comb begin
        logic       mode_mains;
        logic       mode_batt;
        logic       mode_halt;
        logic       temp_single_ok;
        logic       temp_bg_ok;
        logic       batt_single_ok;
        logic       batt_bg_ok;
        logic       temp_event;
        logic       batt_event;
        logic [2:0] temp_code;
        mode_mains     = (I_POWER_MODE == hkad_pkg::HKAD_MODE_MAINS);
        mode_batt      = (I_POWER_MODE == hkad_pkg::HKAD_MODE_BATTERY);
        mode_halt      = (I_POWER_MODE == hkad_pkg::HKAD_MODE_HALTED);
        temp_single_ok = mode_mains | mode_batt;
        temp_bg_ok     = mode_mains | mode_halt;
        batt_single_ok = mode_mains | mode_batt;
        batt_bg_ok     = mode_mains;
        temp_event     = 1'b0;
        batt_event     = 1'b0;
        temp_code      = st_r.delta[hkad_pkg::DELTA_TEMP_LSB +: hkad_pkg::DELTA_FIELD_W];

        st_nxt            = st_r;
        st_nxt.temp_start = 1'b0;
        st_nxt.batt_start = 1'b0;
        st_nxt.temp_irq   = 1'b0;

        // Background ticks, dropped when the mode forbids them
        if (temp_expire && temp_bg_ok) begin
            st_nxt.temp_bg_pend = 1'b1;
        end
        if (batt_expire && batt_bg_ok) begin
            st_nxt.batt_bg_pend = 1'b1;
        end

        // Temperature channel
        unique case (st_r.temp_st)
            hkad_pkg::HKAD_CH_IDLE: begin
                if (st_r.start_req[hkad_pkg::START_TEMP_BIT] && temp_single_ok) begin
                    st_nxt.start_req[hkad_pkg::START_TEMP_BIT] = 1'b0;
                    st_nxt.temp_single = 1'b1;
                    st_nxt.temp_start  = 1'b1;
                    st_nxt.temp_st     = hkad_pkg::HKAD_CH_BUSY;
                end else if (st_nxt.temp_bg_pend && temp_bg_ok) begin
                    st_nxt.temp_bg_pend = 1'b0;
                    st_nxt.temp_single  = 1'b0;
                    st_nxt.temp_start   = 1'b1;
                    st_nxt.temp_st      = hkad_pkg::HKAD_CH_BUSY;
                end
            end
            hkad_pkg::HKAD_CH_BUSY: begin
                if (I_TEMP_CONV_DONE) begin
                    st_nxt.temp_st = hkad_pkg::HKAD_CH_IDLE;
                    // Single completion or delta exceedance, one interrupt
                    temp_event = st_r.temp_single
                               | delta_hit(I_TEMP_CONV_DATA, st_r.temp_ref,
                                           temp_code);
                end
            end
        endcase

        if (temp_event) begin
            st_nxt.temp_irq    = 1'b1;
            st_nxt.temp_result = I_TEMP_CONV_DATA;
            st_nxt.temp_ref    = I_TEMP_CONV_DATA;
        end

        // Battery channel
        unique case (st_r.batt_st)
            hkad_pkg::HKAD_CH_IDLE: begin
                if (st_r.start_req[hkad_pkg::START_BATT_BIT] && batt_single_ok) begin
                    st_nxt.start_req[hkad_pkg::START_BATT_BIT] = 1'b0;
                    st_nxt.batt_single = 1'b1;
                    st_nxt.batt_start  = 1'b1;
                    st_nxt.batt_st     = hkad_pkg::HKAD_CH_BUSY;
                end else if (st_nxt.batt_bg_pend && batt_bg_ok) begin
                    st_nxt.batt_bg_pend = 1'b0;
                    st_nxt.batt_single  = 1'b0;
                    st_nxt.batt_start   = 1'b1;
                    st_nxt.batt_st      = hkad_pkg::HKAD_CH_BUSY;
                end
            end
            hkad_pkg::HKAD_CH_BUSY: begin
                if (I_BATT_CONV_DONE) begin
                    st_nxt.batt_st = hkad_pkg::HKAD_CH_IDLE;
                    batt_event = st_r.batt_single
                               | (I_BATT_CONV_DATA < st_r.low_batt_th);
                end
            end
        endcase

        // Register writes
        if (I_SFR_WR) begin
            unique case (I_SFR_ADDR)
                hkad_pkg::ADDR_MEASURE_START: begin
                    st_nxt.start_req = st_nxt.start_req
                                     | I_SFR_WDATA[hkad_pkg::START_W-1:0];
                end
                hkad_pkg::ADDR_INTERVAL: begin
                    st_nxt.interval = I_SFR_WDATA[hkad_pkg::IVL_STORE_W-1:0];
                end
                hkad_pkg::ADDR_DELTA: begin
                    st_nxt.delta = I_SFR_WDATA[hkad_pkg::DELTA_STORE_W-1:0];
                end
                hkad_pkg::ADDR_LOW_BATT_TH: begin
                    st_nxt.low_batt_th = I_SFR_WDATA;
                end
                hkad_pkg::ADDR_EVENT_FLAGS: begin
                    st_nxt.low_batt_flag = I_SFR_WDATA[hkad_pkg::FLAG_LOW_BATT_BIT];
                end
                hkad_pkg::ADDR_EVENT_ENABLES: begin
                    st_nxt.low_batt_en = I_SFR_WDATA[hkad_pkg::ENABLE_LOW_BATT_BIT];
                end
                default: begin
                end
            endcase
        end

        // Hardware set wins over a software clear
        if (batt_event) begin
            st_nxt.low_batt_flag = 1'b1;
            st_nxt.batt_result   = I_BATT_CONV_DATA;
        end

        st_nxt.psi = st_nxt.low_batt_flag & st_nxt.low_batt_en;

        // Read data for the addressed register
        st_nxt.rdata = hkad_pkg::BYTE_RESET;
        unique case (I_SFR_ADDR)
            hkad_pkg::ADDR_TEMP_RESULT:   st_nxt.rdata = st_r.temp_result;
            hkad_pkg::ADDR_BATT_RESULT:   st_nxt.rdata = st_r.batt_result;
            hkad_pkg::ADDR_MEASURE_START: st_nxt.rdata = {6'h00, st_r.start_req};
            hkad_pkg::ADDR_INTERVAL:      st_nxt.rdata = {4'h0, st_r.interval};
            hkad_pkg::ADDR_DELTA:         st_nxt.rdata = {2'h0, st_r.delta};
            hkad_pkg::ADDR_LOW_BATT_TH:   st_nxt.rdata = st_r.low_batt_th;
            hkad_pkg::ADDR_EVENT_FLAGS: begin
                st_nxt.rdata[hkad_pkg::FLAG_LOW_BATT_BIT] = st_r.low_batt_flag;
            end
            hkad_pkg::ADDR_EVENT_ENABLES: begin
                st_nxt.rdata[hkad_pkg::ENABLE_LOW_BATT_BIT] = st_r.low_batt_en;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            st_r         <= '0;
            st_r.temp_st <= hkad_pkg::HKAD_CH_IDLE;
            st_r.batt_st <= hkad_pkg::HKAD_CH_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign O_SFR_RDATA              = st_r.rdata;
    assign O_TEMP_CONV_START        = st_r.temp_start;
    assign O_BATT_CONV_START        = st_r.batt_start;
    assign O_TEMP_INTERRUPT         = st_r.temp_irq;
    assign O_POWER_SUPPLY_INTERRUPT = st_r.psi;

endmodule : hkad_sequencer

// File: sim/hkad_conv_model.sv
`timescale 1ns/1ps
module hkad_conv_model (
    input  wire logic       i_clk,
    input  wire logic       i_start,
    input  wire logic [7:0] i_value,
    output logic            o_done,
    output logic [7:0]      o_data
);
    int cnt_r = 0;
    initial begin
        o_done = 1'h0;
        o_data = 8'hA5;
    end
    // Data toggles outside the done cycle
    always @(posedge i_clk) begin
        if (i_start) begin
            cnt_r  <= 3;
            o_done <= 1'h0;
            o_data <= ~o_data;
        end else if (cnt_r == 1) begin
            cnt_r  <= 0;
            o_done <= 1'h1;
            o_data <= i_value;
        end else begin
            cnt_r  <= (cnt_r > 0) ? cnt_r - 1 : 0;
            o_done <= 1'h0;
            o_data <= ~o_data;
        end
    end
endmodule : hkad_conv_model

// File: sim/hkad_seq_checker.sv
`timescale 1ns/1ps
module hkad_seq_checker #(
    parameter int unsigned SEC_CYCLES = 4
) (
    input wire logic       I_CLK_SYS,
    input wire logic       I_RST_N,
    input wire logic [7:0] I_SFR_ADDR,
    input wire logic       I_SFR_WR,
    input wire logic [7:0] I_SFR_WDATA,
    input wire logic [1:0] I_POWER_MODE,
    input wire logic       I_TEMP_CONV_DONE,
    input wire logic [7:0] I_TEMP_CONV_DATA,
    input wire logic       I_BATT_CONV_DONE,
    input wire logic [7:0] I_BATT_CONV_DATA,
    input wire logic [7:0] O_SFR_RDATA,
    input wire logic       O_TEMP_CONV_START,
    input wire logic       O_BATT_CONV_START,
    input wire logic       O_TEMP_INTERRUPT,
    input wire logic       O_POWER_SUPPLY_INTERRUPT
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    sequence temp_launch_s; O_TEMP_CONV_START ##1 !O_TEMP_CONV_START; endsequence
    sequence batt_launch_s; O_BATT_CONV_START ##1 !O_BATT_CONV_START; endsequence
    temp_start_pulse_a: assert property (O_TEMP_CONV_START |-> temp_launch_s)
        else $error("temperature start longer than one cycle");
    batt_start_pulse_a: assert property (O_BATT_CONV_START |-> batt_launch_s)
        else $error("battery start longer than one cycle");
    temp_start_mode_a: assert property (O_TEMP_CONV_START |-> $past(I_POWER_MODE) != 2'h3)
        else $error("temperature start in a forbidden mode");
    batt_start_mode_a: assert property (O_BATT_CONV_START |-> $past(I_POWER_MODE) < 2'h2)
        else $error("battery start in a forbidden mode");
    temp_irq_cause_a: assert property (O_TEMP_INTERRUPT |-> $past(I_TEMP_CONV_DONE))
        else $error("temperature interrupt without conversion");
    temp_irq_once_a: assert property (O_TEMP_INTERRUPT |=> !O_TEMP_INTERRUPT)
        else $error("temperature interrupt repeated");
    temp_hold_a: assert property ((I_SFR_ADDR == 8'hD7 && $past(I_SFR_ADDR) == 8'hD7
        && !O_TEMP_INTERRUPT && !$past(O_TEMP_INTERRUPT) && !$past(O_TEMP_INTERRUPT, 2)
        && $past(I_SFR_ADDR, 2) == 8'hD7) |=> $stable(O_SFR_RDATA))
        else $error("temperature result changed without interrupt");
    batt_hold_a: assert property ((I_SFR_ADDR == 8'hDF && $past(I_SFR_ADDR) == 8'hDF
        && !I_BATT_CONV_DONE && !$past(I_BATT_CONV_DONE)) |=> $stable(O_SFR_RDATA))
        else $error("battery result changed without conversion");
    psi_cause_a: assert property ($rose(O_POWER_SUPPLY_INTERRUPT) |-> $past(I_SFR_WR)
        || $past(I_SFR_WR, 2) || $past(I_BATT_CONV_DONE) || $past(I_BATT_CONV_DONE, 2))
        else $error("power interrupt rose without cause");
endmodule : hkad_seq_checker

bind hkad_sequencer hkad_seq_checker #(.SEC_CYCLES(SEC_CYCLES)) i_hkad_seq_checker (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_SFR_ADDR(I_SFR_ADDR), .I_SFR_WR(I_SFR_WR),
    .I_SFR_WDATA(I_SFR_WDATA), .I_POWER_MODE(I_POWER_MODE),
    .I_TEMP_CONV_DONE(I_TEMP_CONV_DONE), .I_TEMP_CONV_DATA(I_TEMP_CONV_DATA),
    .I_BATT_CONV_DONE(I_BATT_CONV_DONE), .I_BATT_CONV_DATA(I_BATT_CONV_DATA),
    .O_SFR_RDATA(O_SFR_RDATA), .O_TEMP_CONV_START(O_TEMP_CONV_START),
    .O_BATT_CONV_START(O_BATT_CONV_START), .O_TEMP_INTERRUPT(O_TEMP_INTERRUPT),
    .O_POWER_SUPPLY_INTERRUPT(O_POWER_SUPPLY_INTERRUPT));

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk = 1'h0, rst_n = 1'h0, wr = 1'h0, rd_v = 1'h0, rd_pend = 1'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, t_val = 8'h00, b_val = 8'h00, v;
    logic [1:0] mode = 2'h0;
    logic [7:0] t_data, b_data, rdata;
    logic       t_done, b_done, t_start, b_start, t_irq, psi;
    logic [7:0] rq[$];
    logic [7:0] alist[10] = '{8'hD7, 8'hDF, 8'hEF, 8'hD8, 8'hF9, 8'hF3, 8'hFA, 8'hF8,
                              8'hEC, 8'h00};
    int mismatches = 0, comparisons = 0, cyc = 0, irq_cnt = 0, exp_irq = 0;
    int seed = 32'h7ECC;
    always #20 clk = ~clk;
    hkad_sequencer #(.SEC_CYCLES(4)) i_hkad_sequencer (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_SFR_ADDR(addr), .I_SFR_WR(wr),
        .I_SFR_WDATA(wdata), .I_POWER_MODE(mode), .I_TEMP_CONV_DONE(t_done),
        .I_TEMP_CONV_DATA(t_data), .I_BATT_CONV_DONE(b_done), .I_BATT_CONV_DATA(b_data),
        .O_SFR_RDATA(rdata), .O_TEMP_CONV_START(t_start), .O_BATT_CONV_START(b_start),
        .O_TEMP_INTERRUPT(t_irq), .O_POWER_SUPPLY_INTERRUPT(psi));
    hkad_conv_model i_hkad_conv_model_t (.i_clk(clk), .i_start(t_start), .i_value(t_val),
        .o_done(t_done), .o_data(t_data));
    hkad_conv_model i_hkad_conv_model_b (.i_clk(clk), .i_start(b_start), .i_value(b_val),
        .o_done(b_done), .o_data(b_data));
    task print_verdict;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask : cmp8
    task cmp1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: bit %b, want %b", $time, got, exp);
        end
    endtask : cmp1
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk);
        wr    <= 1'h0;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_v <= 1'h1;
        rq.push_back(e);
        @(posedge clk);
        rd_v <= 1'h0;
    endtask : rd_reg
    task wait_start(input bit batt, input bit want);
        bit seen;
        seen = 1'b0;
        for (int i = 0; i < 400 && !seen; i++) begin
            @(negedge clk);
            if ((batt ? b_start : t_start) === 1'h1)
                seen = 1'b1;
        end
        cmp1(seen, want);
    endtask : wait_start
    task conv(input bit batt, input logic [7:0] x, input bit irq);
        wait_start(batt, 1'b1);
        @(posedge clk);
        if (batt)
            b_val <= x;
        else
            t_val <= x;
        repeat (8) @(posedge clk);
        exp_irq += (irq && !batt) ? 1 : 0;
        cmp8(8'(irq_cnt), 8'(exp_irq));
    endtask : conv
    // Read results compared in order of request
    always @(posedge clk) rd_pend <= rd_v;
    always @(negedge clk) begin
        if (rd_pend)
            cmp8(rdata, rq.pop_front());
        if (t_irq === 1'h1)
            irq_cnt++;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        foreach (alist[i]) rd_reg(alist[i], 8'h00);
        $display("test reset values done");
        v = 8'($random(seed)) & 8'h7F;
        wr_reg(8'hD8, 8'h02);
        conv(1'b0, v, 1'b1);
        rd_reg(8'hD7, v);
        rd_reg(8'hD8, 8'h00);
        wr_reg(8'hF3, 8'h10);
        wr_reg(8'hF9, 8'h03);
        conv(1'b0, v + 8'h02, 1'b0);
        rd_reg(8'hD7, v);
        conv(1'b0, v + 8'h05, 1'b1);
        rd_reg(8'hD7, v + 8'h05);
        conv(1'b0, v + 8'h03, 1'b0);
        wr_reg(8'hF3, 8'h38);
        conv(1'b0, v + 8'h03, 1'b1);
        wr_reg(8'hF3, 8'h00);
        conv(1'b0, v + 8'h5A, 1'b0);
        @(posedge clk) mode <= 2'h1;
        wait_start(1'b0, 1'b0);
        @(posedge clk) mode <= 2'h2;
        conv(1'b0, v, 1'b0);
        @(posedge clk) mode <= 2'h0;
        wr_reg(8'hF9, 8'h02);
        wait_start(1'b0, 1'b0);
        conv(1'b0, v, 1'b0);
        wr_reg(8'hF9, 8'h00);
        wait_start(1'b0, 1'b0);
        $display("test temperature done");
        wr_reg(8'hFA, 8'h80);
        wr_reg(8'hEC, 8'h04);
        @(posedge clk) mode <= 2'h1;
        wr_reg(8'hD8, 8'h01);
        conv(1'b1, 8'h90, 1'b0);
        @(negedge clk) cmp1(psi, 1'h1);
        rd_reg(8'hDF, 8'h90);
        rd_reg(8'hF8, 8'h04);
        wr_reg(8'hF8, 8'h00);
        wr_reg(8'hEC, 8'h00);
        @(posedge clk) mode <= 2'h0;
        wr_reg(8'hF9, 8'h0C);
        conv(1'b1, 8'hA0, 1'b0);
        rd_reg(8'hDF, 8'h90);
        rd_reg(8'hF8, 8'h00);
        conv(1'b1, 8'h70, 1'b0);
        rd_reg(8'hDF, 8'h70);
        @(negedge clk) cmp1(psi, 1'h0);
        wr_reg(8'hEC, 8'h04);
        repeat (3) @(posedge clk);
        @(negedge clk) cmp1(psi, 1'h1);
        @(posedge clk) mode <= 2'h2;
        wait_start(1'b1, 1'b0);
        $display("test battery done");
        @(posedge clk) mode <= 2'h3;
        wr_reg(8'hD8, 8'h03);
        wait_start(1'b0, 1'b0);
        wait_start(1'b1, 1'b0);
        rd_reg(8'hD8, 8'h03);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rd_reg(8'hD7, 8'h00);
        rd_reg(8'hDF, 8'h00);
        rd_reg(8'hD8, 8'h00);
        $display("test idle mode and reset done");
        print_verdict();
    end
endmodule : tb
